// *** core/scw_core.v ***
// Purpose: Reset, wait state, chip select and option control
// Assumes: Bus strobes synchronous to i_clk_sys, active low
// Notes: Registers sit behind the EE/EF indirect port
`timescale 1ns/10ps
`default_nettype none
`include "scw_regs.vh"
module scw_core #(
  parameter POR_CYCLES = `SCW_POR_MIN_MS * `SCW_CLK_KHZ,
  parameter POR_W = 18
) (
  input wire i_clk_sys,
  input wire i_reset,
  input wire [15:0] i_addr,
  input wire [7:0] i_data,
  output reg [7:0] o_data,
  output wire o_data_oe,
  input wire i_mreq_n,
  input wire i_io_request_n,
  input wire i_rd_n,
  input wire i_wr_n,
  input wire i_opcode_fetch_n,
  input wire i_wait_n,
  output wire o_wait_n,
  output wire o_wait_pin_out,
  output wire o_wait_pin_oe,
  input wire i_reset_pin_n,
  output wire o_reset_pin_out,
  output wire o_reset_pin_oe,
  output wire o_system_reset,
  output wire o_select_low_n,
  output wire o_select_high_n,
  input wire i_clock_external,
  output wire o_generator_bypass,
  output wire o_crc32_sel_a,
  input wire i_evaluation_input,
  output wire o_core_isolate,
  output wire o_bus_oe,
  input wire i_bus_grant_core_n,
  output wire o_bus_grant_n_out,
  output wire o_bus_grant_n_oe,
  output wire o_bus_request_n_oe
);

  ////////////////////////////////////////////////////////////
  // Registers and strobe history
  reg [7:0] sysctl_pointer;
  reg [7:0] wait_state_control;
  reg [7:0] memory_wait_limit;
  reg [7:0] select_boundary;
  reg [7:0] misc_option_control;
  reg mreq_q;
  reg io_request_n_q;
  reg rd_q;
  reg wr_q;
  reg pin_q;
  reg prev_prefix;
  reg interrupt_return_check;
  reg ev_mode;
  reg ev_taken;
  reg [POR_W-1:0] por_cnt;
  reg [4:0] stretch_cnt;

  wire m1;
  wire [3:0] hi4;
  wire mem_start;
  wire io_start;
  wire io_sel_ptr;
  wire io_sel_data;
  wire io_sel;
  wire wr_fall;
  wire onchip;
  wire in_mwait;
  wire [1:0] mem_w;
  wire [1:0] io_w;
  wire [1:0] chain_w;
  wire opc_en;
  wire vec_en;
  wire por_active;
  wire stretch_active;
  wire ext_fall;
  wire prog_busy;
  wire chain_busy;
  wire int_wait;

  assign m1 = ~i_opcode_fetch_n;
  assign hi4 = i_addr[15:12];
  assign mem_start = mreq_q & ~i_mreq_n;
  assign io_start = io_request_n_q & ~i_io_request_n;
  assign mem_w = wait_state_control[`SCW_WAIT_MEM_HI:`SCW_WAIT_MEM_LO];
  assign io_w = wait_state_control[`SCW_WAIT_IO_HI:`SCW_WAIT_IO_LO];
  assign chain_w = wait_state_control[`SCW_WAIT_CHAIN_HI:`SCW_WAIT_CHAIN_LO];
  assign opc_en = wait_state_control[`SCW_WAIT_OPC_BIT];
  assign vec_en = wait_state_control[`SCW_WAIT_VEC_BIT];

  ////////////////////////////////////////////////////////////
  // Full 8-bit decode of on-chip peripheral addresses
  function is_onchip;
    input [7:0] a;
    begin
      is_onchip = (a[7:2] == 6'b0001_00) || // RQ24
        (a[7:3] == 5'b0001_1) ||
        (a == 8'hEE) || (a == 8'hEF) ||
        (a == 8'hF0) || (a == 8'hF1) ||
        (a == 8'hF4);
    end
  endfunction

  assign onchip = is_onchip(i_addr[7:0]);

  ////////////////////////////////////////////////////////////
  // Indirect register port
  assign io_sel_ptr = (i_addr[7:0] == `SCW_PTR_ADDR); // RQ20
  assign io_sel_data = (i_addr[7:0] == `SCW_DATA_ADDR); // RQ20
  assign io_sel = (io_sel_ptr | io_sel_data) & ~i_io_request_n & i_opcode_fetch_n;
  assign wr_fall = wr_q & ~i_wr_n & io_sel;

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      sysctl_pointer <= 8'h00;
      wait_state_control <= `SCW_WAIT_RST;
      memory_wait_limit <= `SCW_MWAIT_RST;
      select_boundary <= `SCW_SEL_RST; // RQ16
      misc_option_control <= `SCW_MISC_RST; // RQ16
    end else if (wr_fall) begin
      if (io_sel_ptr) begin
        sysctl_pointer <= i_data;
      end else if (sysctl_pointer == `SCW_IDX_WAIT) begin
        wait_state_control <= i_data; // RQ23
      end else if (sysctl_pointer == `SCW_IDX_MWAIT) begin
        memory_wait_limit <= i_data; // RQ23
      end else if (sysctl_pointer == `SCW_IDX_SEL) begin
        select_boundary <= i_data; // RQ23
      end else if (sysctl_pointer == `SCW_IDX_MISC) begin
        misc_option_control <= i_data; // RQ23
      end
    end
  end

  // Read data is registered; an unknown index reads as zero
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_data <= 8'h00;
    end else if (io_sel_ptr) begin
      o_data <= sysctl_pointer;
    end else if (sysctl_pointer == `SCW_IDX_WAIT) begin
      o_data <= wait_state_control;
    end else if (sysctl_pointer == `SCW_IDX_MWAIT) begin
      o_data <= memory_wait_limit;
    end else if (sysctl_pointer == `SCW_IDX_SEL) begin
      o_data <= select_boundary;
    end else if (sysctl_pointer == `SCW_IDX_MISC) begin
      o_data <= misc_option_control;
    end else begin
      o_data <= 8'h00;
    end
  end

  assign o_data_oe = io_sel & ~i_rd_n & ~rd_q;

  ////////////////////////////////////////////////////////////
  // Strobe history
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      mreq_q <= 1'b1;
      io_request_n_q <= 1'b1;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      pin_q <= 1'b1;
    end else begin
      mreq_q <= i_mreq_n;
      io_request_n_q <= i_io_request_n;
      rd_q <= i_rd_n;
      wr_q <= i_wr_n;
      pin_q <= i_reset_pin_n;
    end
  end

  ////////////////////////////////////////////////////////////
  // Wait state generation
  assign in_mwait = (hi4 >= memory_wait_limit[3:0]) && (hi4 <= memory_wait_limit[7:4]);

  reg prog_load;
  reg [2:0] prog_value;
  reg chain_load;
  reg [2:0] chain_value;

  always @* begin
    prog_load = 1'b0;
    prog_value = 3'd0;
    chain_load = 1'b0;
    chain_value = 3'd0;
    if (mem_start) begin
      prog_load = 1'b1;
      if (in_mwait) begin
        prog_value = {1'b0, mem_w} + {2'b00, m1 & opc_en}; // RQ6 RQ7
      end
      if (m1 && prev_prefix && chain_w[1]) begin
        chain_load = 1'b1; // RQ12
        chain_value = chain_w[0] ? 3'd4 : 3'd2; // RQ12
      end
    end else if (io_start && !m1) begin
      prog_load = 1'b1;
      prog_value = onchip ? 3'd0 : {io_w, 1'b0}; // RQ8 RQ9
    end else if (io_start && m1) begin
      chain_load = 1'b1;
      chain_value = {chain_w, 1'b0} + {2'b00, vec_en}; // RQ10 RQ11
    end
  end

  // Return opcode check: a non-return byte keeps only one wait
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      prev_prefix <= 1'b0;
      interrupt_return_check <= 1'b0;
    end else begin
      interrupt_return_check <= chain_load & mem_start;
      // Strobes all rise together, so keep the last byte seen during the fetch
      if (m1 && !i_rd_n && !i_mreq_n) begin
        prev_prefix <= (i_data == `SCW_OP_PREFIX); // RQ12
      end
    end
  end

  scw_wait_count #(
    .W(3)
  ) u_prog_wait (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_load(prog_load),
    .i_value(prog_value),
    .i_clear(1'b0),
    .o_busy(prog_busy)
  );

  scw_wait_count #(
    .W(3)
  ) u_chain_wait (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_load(chain_load),
    .i_value(chain_value),
    .i_clear(interrupt_return_check & (i_data != `SCW_OP_RETURN)), // RQ12
    .o_busy(chain_busy)
  );

  // Start cycle counts as wait too, so no edge slips past
  assign int_wait = prog_busy | chain_busy | prog_load | chain_load; // RQ25

  // External wait is ignored while programmed waits run,
  // except during chain waits where it is simply ORed
  assign o_wait_n = ~(int_wait | (~i_wait_n & ~ev_mode & (~(prog_busy | prog_load)))); // RQ13 RQ25

  assign o_wait_pin_oe = ev_mode; // RQ22
  assign o_wait_pin_out = ~int_wait; // RQ22

  ////////////////////////////////////////////////////////////
  // Chip selects, unqualified by strobes
  assign o_select_low_n = ~(misc_option_control[`SCW_MISC_SELLO_EN_BIT] &
    (hi4 <= select_boundary[3:0])); // RQ14 RQ17
  assign o_select_high_n = ~(misc_option_control[`SCW_MISC_SELHI_EN_BIT] &
    (hi4 <= select_boundary[7:4]) & (hi4 > select_boundary[3:0])); // RQ15 RQ17

  ////////////////////////////////////////////////////////////
  // Option outputs
  assign o_generator_bypass = misc_option_control[`SCW_MISC_DIV1_BIT] & ~i_clock_external; // RQ18
  assign o_crc32_sel_a = misc_option_control[`SCW_MISC_CRC32_BIT]; // RQ19

  ////////////////////////////////////////////////////////////
  // Power-on and stretched reset; pin is open drain low only
  assign por_active = (por_cnt != {POR_W{1'b0}});
  assign stretch_active = (stretch_cnt != 5'd0);
  assign ext_fall = pin_q & ~i_reset_pin_n & ~o_reset_pin_oe;

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      por_cnt <= POR_CYCLES[POR_W-1:0]; // RQ1
    end else if (por_active) begin
      por_cnt <= por_cnt - {{(POR_W-1){1'b0}}, 1'b1}; // RQ2
    end
  end

  // Outside pulses that span no rising clock edge may be missed
  always @(posedge i_clk_sys) begin
    if (i_reset || por_active) begin
      stretch_cnt <= 5'd0;
    end else if (ext_fall && !misc_option_control[`SCW_MISC_RSTDIS_BIT]) begin
      stretch_cnt <= 5'd`SCW_STRETCH_CLKS; // RQ3 RQ5
    end else if (stretch_active) begin
      stretch_cnt <= stretch_cnt - 5'd1; // RQ3
    end
  end

  assign o_reset_pin_out = 1'b0;
  assign o_reset_pin_oe = por_active | stretch_active; // RQ2 RQ5
  assign o_system_reset = i_reset | ~i_reset_pin_n | por_active; // RQ4

  ////////////////////////////////////////////////////////////
  // Evaluation strap, caught once after reset release
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      ev_mode <= 1'b0;
      ev_taken <= 1'b0;
    end else if (!ev_taken) begin
      ev_mode <= i_evaluation_input; // RQ21
      ev_taken <= 1'b1;
    end
  end

  assign o_core_isolate = ev_mode; // RQ21
  assign o_bus_oe = ~ev_mode; // RQ21
  assign o_bus_request_n_oe = 1'b0;
  assign o_bus_grant_n_out = i_bus_grant_core_n;
  assign o_bus_grant_n_oe = ~ev_mode; // RQ22
endmodule // scw_core
`default_nettype wire

// *** core/scw_regs.vh ***
// Purpose: Constants for the system control, wait and chip select block
// Assumes: 10 MHz system clock, 8-bit indirect register port
// Notes: Offsets, fields, reset values and counts live here, except the pointer reset of 00 in the core
//
// How it works
// RQ1: Power-on holds reset low 25 to 75 ms
// RQ2: Power-on drive released when interval ends
// RQ3: External reset stretched to 16 clocks
// RQ4: Outside source holds reset at least 3 clocks
// RQ5: Misc bit 3 disables reset output drive (code gates only the stretch, not the power-on drive)
// RQ6: Zero to three memory waits in range
// RQ7: Optional extra wait on opcode fetch
// RQ8: Zero, two, four or six I/O waits
// RQ9: No I/O waits for on-chip peripherals
// RQ10: Optional vector wait in interrupt acknowledge
// RQ11: Daisy waits between fetch and I/O strobe
// RQ12: Return fetch extended when daisy is 4/6
// RQ13: External wait sampled after internal waits (code masks it during programmed waits and ORs it with chain waits)
// RQ14: Select low active at or below low boundary
// RQ15: Select high between low and high boundary
// RQ16: Select low enabled at F after power-up
// RQ17: Selects decode A15-A12 only, unqualified
// RQ18: Misc bit 4 bypasses clock divide-by-two
// RQ19: Misc bit 2 selects 32-bit CRC
// RQ20: Registers reached by pointer EE, data EF
// RQ21: Evaluation strap isolates core, floats bus
// RQ22: Evaluation: wait pin out, grant floated
// RQ23: Index 00 to 03 select four registers
// RQ24: On-chip I/O fully decoded from A7-A0
// RQ25: Internal waits complete, ORed with external
`ifndef SCW_REGS_VH
`define SCW_REGS_VH

`define SCW_PTR_ADDR 8'hEE
`define SCW_DATA_ADDR 8'hEF

`define SCW_IDX_WAIT 8'h00
`define SCW_IDX_MWAIT 8'h01
`define SCW_IDX_SEL 8'h02
`define SCW_IDX_MISC 8'h03

`define SCW_WAIT_RST 8'h00
`define SCW_MWAIT_RST 8'hF0
`define SCW_SEL_RST 8'h0F
`define SCW_MISC_RST 8'h01

`define SCW_WAIT_MEM_HI 7
`define SCW_WAIT_MEM_LO 6
`define SCW_WAIT_IO_HI 5
`define SCW_WAIT_IO_LO 4
`define SCW_WAIT_CHAIN_HI 3
`define SCW_WAIT_CHAIN_LO 2
`define SCW_WAIT_OPC_BIT 1
`define SCW_WAIT_VEC_BIT 0

`define SCW_MISC_DIV1_BIT 4
`define SCW_MISC_RSTDIS_BIT 3
`define SCW_MISC_CRC32_BIT 2
`define SCW_MISC_SELHI_EN_BIT 1
`define SCW_MISC_SELLO_EN_BIT 0

`define SCW_OP_PREFIX 8'hED
`define SCW_OP_RETURN 8'h4D

`define SCW_CLK_KHZ 10000
`define SCW_POR_MIN_MS 25
`define SCW_POR_MAX_MS 75
`define SCW_STRETCH_CLKS 16
`define SCW_EXT_RST_MIN_CLKS 3

`endif

// *** core/scw_wait_count.v ***
// Purpose: Loadable down counter holding off a bus cycle
// Assumes: Load and clear are single-cycle strobes
// Notes: Busy stays high while any wait remains
`timescale 1ns/10ps
`default_nettype none
module scw_wait_count #(
  parameter W = 3
) (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_load,
  input wire [W-1:0] i_value,
  input wire i_clear,
  output wire o_busy
);
  reg [W-1:0] count;

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      count <= {W{1'b0}};
    end else if (i_load) begin
      count <= i_value;
    end else if (i_clear) begin
      count <= {W{1'b0}};
    end else if (count != {W{1'b0}}) begin
      count <= count - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign o_busy = (count != {W{1'b0}});
endmodule // scw_wait_count
`default_nettype wire

// *** tb/scw_core_properties.sv ***
// Purpose: Port-level checks of scw_core
// Assumes: One clock, synchronous active-high reset
// Notes: Bound into every scw_core instance
`timescale 1ns/10ps
`default_nettype none
module scw_core_properties #(
  parameter POR_CYCLES = 20
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [15:0] i_addr,
  input wire logic i_wr_n,
  input wire logic i_io_request_n,
  input wire logic i_opcode_fetch_n,
  input wire logic i_wait_n,
  input wire logic o_wait_n,
  input wire logic o_wait_pin_oe,
  input wire logic i_reset_pin_n,
  input wire logic o_reset_pin_oe,
  input wire logic o_system_reset,
  input wire logic o_select_low_n,
  input wire logic o_select_high_n,
  input wire logic i_clock_external,
  input wire logic o_generator_bypass,
  input wire logic o_core_isolate,
  input wire logic o_bus_oe,
  input wire logic o_bus_grant_n_oe,
  input wire logic o_bus_request_n_oe
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////
  // Counts the power-on drive; later drives are stretches
  int por_cnt;
  logic por_done;
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      por_cnt <= 0;
      por_done <= 1'b0;
    end else begin
      if (o_reset_pin_oe && !por_done) por_cnt <= por_cnt + 1;
      if ($fell(o_reset_pin_oe)) por_done <= 1'b1;
    end
  end
  sequence s_hold16;
    o_reset_pin_oe [*8] ##1 o_reset_pin_oe [*8];
  endsequence
  sequence s_onchip_io;
    $fell(i_io_request_n) && i_opcode_fetch_n && i_addr[7:1] == 7'h77 && !o_core_isolate;
  endsequence
  ////////////////////////////////////////
  AST_POR_HOLD: assert property ($fell(i_reset) |-> o_reset_pin_oe [*8]) else $error("power-on drive short");
  AST_POR_LEN: assert property ($fell(o_reset_pin_oe) && !por_done |->
    por_cnt >= POR_CYCLES - 1 && por_cnt <= 3 * POR_CYCLES) else $error("power-on length");
  AST_STRETCH: assert property ($rose(o_reset_pin_oe) && por_done |-> s_hold16 ##1 !o_reset_pin_oe)
    else $error("stretch not 16");
  AST_PIN_RESET: assert property (!i_reset_pin_n |-> o_system_reset) else $error("pin low ignored");
  AST_SEL_EXCL: assert property (!(!o_select_low_n && !o_select_high_n)) else $error("both selects");
  AST_SEL_COMB: assert property ($stable(i_addr[15:12]) && i_wr_n && $past(i_wr_n) |->
    $stable({o_select_low_n, o_select_high_n})) else $error("select moved");
  AST_BYPASS: assert property (o_generator_bypass |-> !i_clock_external) else $error("bypass");
  AST_ONCHIP_IO: assert property (s_onchip_io |=> o_wait_n == i_wait_n) else $error("on-chip wait");
  AST_EXT_OR: assert property (!i_wait_n && !o_core_isolate |-> !o_wait_n) else $error("ext wait lost");
  AST_EVAL: assert property (o_core_isolate |-> !o_bus_oe && !o_bus_grant_n_oe && !o_bus_request_n_oe
    && o_wait_pin_oe) else $error("eval pins");
endmodule // scw_core_properties
bind scw_core scw_core_properties #(.POR_CYCLES(POR_CYCLES)) u_props (.i_clk_sys, .i_reset, .i_addr, .i_wr_n,
  .i_io_request_n, .i_opcode_fetch_n, .i_wait_n, .o_wait_n, .o_wait_pin_oe, .i_reset_pin_n, .o_reset_pin_oe,
  .o_system_reset, .o_select_low_n, .o_select_high_n, .i_clock_external, .o_generator_bypass, .o_core_isolate,
  .o_bus_oe, .o_bus_grant_n_oe, .o_bus_request_n_oe);
`default_nettype wire

// *** tb/scw_core_tb.sv ***
// Purpose: Self-checking bench of scw_core
// Assumes: Inputs move on falling edges
// Notes: Short power-on count keeps the run small
`timescale 1ns/10ps
`default_nettype none
module scw_core_tb;
  localparam int POR = 20;
  logic i_clk_sys = 0, i_reset = 1, i_mreq_n = 1, i_io_request_n = 1, i_rd_n = 1, i_wr_n = 1;
  logic i_opcode_fetch_n = 1, i_wait_n = 1, i_clock_external = 0, i_evaluation_input = 0, ext_low = 0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_data = 8'h00, b;
  wire [7:0] o_data;
  wire o_wait_n, o_wait_pin_oe, i_reset_pin_n, o_reset_pin_out, o_reset_pin_oe, o_select_low_n;
  wire o_select_high_n, o_generator_bypass, o_crc32_sel_a, o_core_isolate, o_bus_oe, o_bus_grant_n_oe;
  wire o_bus_request_n_oe, o_data_oe, o_wait_pin_out, o_system_reset, o_bus_grant_n_out;
  int fail_count = 0, total_checks = 0, seed, i, j, n, e;
  scw_core #(.POR_CYCLES(POR), .POR_W(18)) DUT (.i_clk_sys, .i_reset, .i_addr, .i_data, .o_data, .o_data_oe,
    .i_mreq_n, .i_io_request_n, .i_rd_n, .i_wr_n, .i_opcode_fetch_n, .i_wait_n, .o_wait_n, .o_wait_pin_out,
    .o_wait_pin_oe, .i_reset_pin_n, .o_reset_pin_out, .o_reset_pin_oe, .o_system_reset, .o_select_low_n,
    .o_select_high_n, .i_clock_external, .o_generator_bypass, .o_crc32_sel_a, .i_evaluation_input,
    .o_core_isolate, .o_bus_oe, .i_bus_grant_core_n(1'b1), .o_bus_grant_n_out, .o_bus_grant_n_oe,
    .o_bus_request_n_oe);
  scw_reset_line u_line (.i_drive_oe(o_reset_pin_oe), .i_drive_level(o_reset_pin_out), .i_ext_low(ext_low),
    .o_pin_n(i_reset_pin_n));
  initial begin
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  ////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  task automatic checkn(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      $display("BAD %s expected %0d seen %0d", what, exp, got);
      fail_count++;
    end
  endtask
  function automatic int mx(input int x, input int y);
    return x > y ? x : y;
  endfunction
  function automatic logic [1:0] sel_exp(input logic [7:0] bd, input logic [1:0] en, input logic [3:0] a);
    return {!(en[0] && a <= bd[3:0]), !(en[1] && a <= bd[7:4] && a > bd[3:0])};
  endfunction
  ////////////////////////////////////////
  task automatic io(input logic [7:0] a, input logic wr, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_addr = {8'h00, a};
    i_data = d;
    i_io_request_n = 0;
    i_wr_n = !wr;
    i_rd_n = wr;
    repeat (2) @(negedge i_clk_sys);
    if (!wr) check8("read data", d, o_data);
    if (!wr) check8("data enable", 8'h01, {7'h00, o_data_oe});
    i_io_request_n = 1;
    i_wr_n = 1;
    i_rd_n = 1;
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    io(8'hEE, 1, idx);
    io(8'hEF, 1, d);
  endtask
  task automatic rreg(input logic [7:0] idx, input logic [7:0] d);
    io(8'hEE, 1, idx);
    io(8'hEF, 0, d);
  endtask
  // Counts wait-low cycles from the strobe; ext holds the outside wait low
  task automatic cyc(input logic isio, input logic m1, input logic [15:0] a, input int ext, input int exp);
    int k;
    int c;
    c = 0;
    for (k = 0; k < 40; k++) begin
      @(negedge i_clk_sys);
      i_addr = a;
      i_mreq_n = isio;
      i_io_request_n = !isio;
      i_opcode_fetch_n = !m1;
      i_rd_n = isio && m1;
      i_wait_n = (k >= ext);
      #1;
      if (o_wait_n === 1'b1) break;
      c++;
    end
    if (k == 40) begin
      fail_count++;
      give_verdict();
    end
    @(negedge i_clk_sys);
    {i_mreq_n, i_io_request_n, i_opcode_fetch_n, i_rd_n, i_wait_n} = 5'h1F;
    checkn("wait cycles", exp, c);
  endtask
  task automatic pulse(input int exp);
    int k;
    int c;
    c = 0;
    for (k = 0; k < 30; k++) begin
      @(negedge i_clk_sys);
      ext_low = (k < 3);
      #1;
      if (o_reset_pin_oe === 1'b1) c++;
    end
    checkn("stretch", exp, c);
  endtask
  ////////////////////////////////////////
  initial begin
    seed = 21034;
    repeat (4) @(negedge i_clk_sys);
    i_reset = 0;
    n = 0;
    while (o_reset_pin_oe === 1'b1 && n < 4 * POR) begin
      @(negedge i_clk_sys);
      n++;
    end
    checkn("power-on in range", 1, (n >= POR - 1 && n <= 3 * POR) ? 1 : 0);
    for (i = 0; i < 4; i++) rreg(i[7:0], i == 0 ? 8'h00 : i == 1 ? 8'hF0 : i == 2 ? 8'h0F : 8'h01);
    rreg(8'h07, 8'h00);
    for (i = 0; i < 4; i++) begin
      b = i == 0 ? 8'h0F : $random(seed);
      if (i > 0) wreg(8'h02, b);
      if (i > 0) wreg(8'h03, 8'h03);
      for (j = 0; j < 16; j++) begin
        @(negedge i_clk_sys);
        i_addr = {j[3:0], 12'h000};
        #1;
        check8("selects", {6'h00, sel_exp(b, i == 0 ? 2'b01 : 2'b11, j[3:0])},
          {6'h00, o_select_low_n, o_select_high_n});
      end
    end
    for (i = 0; i < 4; i++) begin
      j = $random(seed) & 3;
      e = $random(seed) & 7;
      wreg(8'h00, {i[1:0], 4'h0, j[0], 1'b0});
      cyc(0, j[1], $random(seed), e, mx(1 + i + (j[0] & j[1]), e));
    end
    wreg(8'h01, 8'h31);
    cyc(0, 1, 16'h8000, 0, 1);
    for (i = 0; i < 4; i++) begin
      e = $random(seed) & 7;
      wreg(8'h00, {2'b00, i[1:0], 4'h0});
      cyc(1, 0, {8'h00, 8'h20 + ($random(seed) & 8'h1F)}, e, mx(1 + 2 * i, e));
      cyc(1, 0, 16'h0018, 0, 1);
      wreg(8'h00, {4'h0, i[1:0], 1'b0, i[0]});
      cyc(1, 1, 16'h0000, 0, 1 + 2 * i + i[0]);
    end
    wreg(8'h00, 8'h08);
    i_data = 8'hED;
    cyc(0, 1, 16'h1000, 0, 1);
    i_data = 8'h4D;
    cyc(0, 1, 16'h1000, 0, 3);
    i_data = 8'hED;
    cyc(0, 1, 16'h1000, 0, 1);
    i_data = 8'h00;
    cyc(0, 1, 16'h1000, 0, 2);
    wreg(8'h03, 8'h01);
    pulse(16);
    wreg(8'h03, 8'h0D);
    pulse(0);
    rreg(8'h03, 8'h0D);
    wreg(8'h03, 8'h15);
    for (i = 0; i < 2; i++) begin
      @(negedge i_clk_sys);
      i_clock_external = i[0];
      #1;
      check8("options", {6'h00, !i[0], 1'b1}, {6'h00, o_generator_bypass, o_crc32_sel_a});
    end
    i_evaluation_input = 1;
    i_reset = 1;
    repeat (4) @(negedge i_clk_sys);
    i_reset = 0;
    repeat (2) @(negedge i_clk_sys);
    check8("eval pins", 8'hF1, {o_system_reset, o_wait_pin_out, o_bus_grant_n_out, o_core_isolate, o_bus_oe,
      o_bus_grant_n_oe, o_bus_request_n_oe, o_wait_pin_oe});
    give_verdict();
  end
endmodule // scw_core_tb
`default_nettype wire

// *** tb/scw_reset_line.sv ***
// Purpose: Reset wire with pull-up and outside reset source
// Assumes: Device side only pulls low
// Notes: Any low driver wins
`timescale 1ns/10ps
`default_nettype none
module scw_reset_line (
  input wire logic i_drive_oe,
  input wire logic i_drive_level,
  input wire logic i_ext_low,
  output logic o_pin_n
);
  // Released wire returns high through the pull-up
  assign o_pin_n = ((i_drive_oe && !i_drive_level) || i_ext_low) ? 1'b0 : 1'b1;
endmodule // scw_reset_line
`default_nettype wire
